// ==== verilog/soft_strap_defines.svh ====
// constants for the soft-strap default block
// What this block does
// - The port 2 energy strap becomes the reset default of the port 2 MAC energy-saving enable.
// - In 100BASE-FX mode the energy strap has no effect and every energy-saving default stays off.
// - The energy strap also sets the PHY B energy enable, 100BASE-TX capability and advertisement defaults.
// - The port 0 speed strap, default 1, sets the four virtual PHY partner speed ability defaults.
// - When virtual auto-negotiation fails, port 0 runs at the speed the speed strap gives.
// - In RMII MAC mode the speed polarity says whether a high or a low speed pin means 100 Mbps.
// - Speed select and speed polarity share one strap bit loaded from one EEPROM bit.
// - The port 0 duplex strap, default 1, sets the partner full and half duplex ability defaults.
// - In MII MAC and RMII MAC modes the duplex polarity says which duplex pin level means full duplex.
// - Duplex select and duplex polarity share one strap bit loaded from one EEPROM bit.
// - The port 0 backpressure strap, default 1, sets the port 0 backpressure enable default.
// - The port 0 flow strap, default 1, sets the transmit and receive flow enable defaults.
// - The same flow strap sets the partner asymmetric pause and pause ability defaults.
// - The EEPROM loader may replace every soft-strap value.
`ifndef SOFT_STRAP_DEFINES_SVH
`define SOFT_STRAP_DEFINES_SVH

// ==========================================================
// register offsets
`define REG_STRAP      8'h00
`define REG_CTRL       8'h04
`define REG_DEFAULTS   8'h08
`define REG_STATUS     8'h0c

// ==========================================================
// strap register fields
`define STRAP_W        5
`define ST_ENERGY      0
`define ST_SPEED       1
`define ST_DUPLEX      2
`define ST_BACKPRESS   3
`define ST_FLOW        4
`define STRAP_RESET    5'h1e

// ==========================================================
// control register fields
`define CTRL_APPLY     0

// ==========================================================
// target default fields
`define DEF_W          13
`define DF_MAC_ENERGY  0
`define DF_PHY_ENERGY  1
`define DF_PHY_CAP     2
`define DF_PHY_ADV     3
`define DF_P100_FD     4
`define DF_P100_HD     5
`define DF_P10_FD      6
`define DF_P10_HD      7
`define DF_ASYM_PAUSE  8
`define DF_PAUSE       9
`define DF_BACKPRESS   10
`define DF_TX_FLOW     11
`define DF_RX_FLOW     12
`define DEF_RESET      13'h0000

// ==========================================================
// status register fields
`define SS_SPEED_100   0
`define SS_FULL_DUPLEX 1
`define SS_LINK_100    2
`define SS_FX_MODE     3
`define SS_AN_FAIL     4
`define SS_BUSY        5

// ==========================================================
// port 0 mac modes and synchroniser
`define MODE_MII_MAC   2'h1
`define MODE_RMII_MAC  2'h2
`define SYNC_W         8
`define SY_ENERGY_PIN  0
`define SY_SPEED_PIN   1
`define SY_DUPLEX_PIN  2
`define SY_FX          3
`define SY_AN_FAIL     4
`define SY_NEG_100     5
`define SY_MODE_LO     6
`define SY_MODE_HI     7

// ==========================================================
// ahb encodings
`define HTRANS_NONSEQ  2'h2
`define HTRANS_SEQ     2'h3
`define ADDR_W         8

`endif

// ==== verilog/soft_strap_pkg.sv ====
// types for the soft-strap default block
`default_nettype none
package soft_strap_pkg;
  typedef enum logic [1:0] {
    st_wait,
    st_latch,
    st_apply,
    st_run
  } init_state_t;
endpackage
`default_nettype wire

// ==== verilog/pin_sync_if.sv ====
// raw pins and their synchronised copies
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
interface pin_sync_if;
  logic [`SYNC_W-1:0] raw;
  logic [`SYNC_W-1:0] synced;
  modport owner (output raw, input synced);
  modport sync  (input raw, output synced);
endinterface
`default_nettype wire

// ==== verilog/pin_synchroniser.sv ====
// two-flop synchroniser for every asynchronous input
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
module pin_synchroniser (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  pin_sync_if.sync    pins
);

  // ==========================================================
  // one pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= pins.raw[i];
          sync_ff <= meta_ff;
        end
      end
      assign pins.synced[i] = sync_ff;
    end
  endgenerate

endmodule // pin_synchroniser
`default_nettype wire

// ==== verilog/soft_strap_default_apply.sv ====
// soft-strap holding and default apply logic with ahb-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
module soft_strap_default_apply (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  energy_saving_strap_pin,
  input  wire logic                  port0_speed_pin,
  input  wire logic                  port0_duplex_pin,
  input  wire logic [1:0]            port0_mac_mode,
  input  wire logic                  phy_fx_mode,
  input  wire logic                  vphy_an_fail,
  input  wire logic                  vphy_an_speed_100,
  input  wire logic                  eeprom_strap_valid,
  input  wire logic [`STRAP_W-1:0]   eeprom_strap_data,
  output logic                       mac_energy_saving_enable,
  output logic                       phy_energy_saving_enable,
  output logic                       phy_energy_saving_capability,
  output logic                       phy_energy_saving_advert,
  output logic [3:0]                 virtual_phy_partner_ability,
  output logic [1:0]                 virtual_phy_partner_pause,
  output logic                       port0_backpressure_enable,
  output logic                       port0_tx_flow_enable,
  output logic                       port0_rx_flow_enable,
  output logic                       defaults_applied,
  output logic                       port0_speed_100,
  output logic                       port0_full_duplex,
  output logic                       port0_link_speed_100
);

  // ==========================================================
  // synchronised pins
  pin_sync_if pins ();

  assign pins.raw = {port0_mac_mode, vphy_an_speed_100, vphy_an_fail, phy_fx_mode,
                     port0_duplex_pin, port0_speed_pin, energy_saving_strap_pin};

  pin_synchroniser u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (pins)
  );

  logic       s_energy_pin;
  logic       s_speed_pin;
  logic       s_duplex_pin;
  logic       s_fx;
  logic       s_an_fail;
  logic       s_neg_100;
  logic [1:0] s_mode;

  assign s_energy_pin = pins.synced[`SY_ENERGY_PIN];
  assign s_speed_pin  = pins.synced[`SY_SPEED_PIN];
  assign s_duplex_pin = pins.synced[`SY_DUPLEX_PIN];
  assign s_fx         = pins.synced[`SY_FX];
  assign s_an_fail    = pins.synced[`SY_AN_FAIL];
  assign s_neg_100    = pins.synced[`SY_NEG_100];
  assign s_mode       = pins.synced[`SY_MODE_HI:`SY_MODE_LO];

  // ==========================================================
  // ahb-lite address phase capture
  logic                 wr_pend_ff;
  logic [`ADDR_W-1:0]   wr_addr_ff;
  logic [31:0]          rdata_ff;
  logic                 addr_ok;
  logic                 rd_req;
  logic                 wr_req;
  logic [`ADDR_W-1:0]   req_addr;

  assign addr_ok  = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign rd_req   = addr_ok && !hwrite;
  assign wr_req   = addr_ok && hwrite;
  assign req_addr = haddr[`ADDR_W-1:0];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= wr_req;
      wr_addr_ff <= req_addr;
    end
  end

  logic wr_strap;
  logic wr_ctrl;
  logic wr_defaults;

  assign wr_strap    = wr_pend_ff && wr_addr_ff == `REG_STRAP;
  assign wr_ctrl     = wr_pend_ff && wr_addr_ff == `REG_CTRL;
  assign wr_defaults = wr_pend_ff && wr_addr_ff == `REG_DEFAULTS;

  // ==========================================================
  // init sequencer
  soft_strap_pkg::init_state_t state_ff;
  soft_strap_pkg::init_state_t nxt_state;
  logic                        apply_req_ff;
  logic                        apply_now;
  logic                        settle_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      soft_strap_pkg::st_wait:  begin
        nxt_state = settle_ff ? soft_strap_pkg::st_latch : soft_strap_pkg::st_wait;
      end
      soft_strap_pkg::st_latch: begin
        nxt_state = soft_strap_pkg::st_apply;
      end
      soft_strap_pkg::st_apply: begin
        nxt_state = soft_strap_pkg::st_run;
      end
      soft_strap_pkg::st_run:   begin
        nxt_state = soft_strap_pkg::st_run;
      end
      default: begin
        nxt_state = soft_strap_pkg::st_wait;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= soft_strap_pkg::st_wait;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // extra wait edge so the synchronised pin copy is valid before the latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_ff <= 1'b0;
    end else begin
      settle_ff <= 1'b1;
    end
  end

  // later apply requests from software or a finished eeprom load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      apply_req_ff <= 1'b0;
    end else begin
      apply_req_ff <= eeprom_strap_valid || (wr_ctrl && hwdata[`CTRL_APPLY]);
    end
  end

  assign apply_now = (state_ff == soft_strap_pkg::st_apply) ||
                     (apply_req_ff && state_ff == soft_strap_pkg::st_run);

  // ==========================================================
  // held strap values
  logic [`STRAP_W-1:0] strap_ff;

  // one bit each for speed and duplex, each serving as both select and polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_ff <= `STRAP_RESET;
    end else if (eeprom_strap_valid) begin
      strap_ff <= eeprom_strap_data;
    end else if (wr_strap) begin
      strap_ff <= hwdata[`STRAP_W-1:0];
    end else if (state_ff == soft_strap_pkg::st_latch) begin
      strap_ff[`ST_ENERGY] <= s_energy_pin;
    end
  end

  logic st_energy;
  logic st_speed;
  logic st_duplex;
  logic st_flow;

  assign st_energy = strap_ff[`ST_ENERGY];
  assign st_speed  = strap_ff[`ST_SPEED];
  assign st_duplex = strap_ff[`ST_DUPLEX];
  assign st_flow   = strap_ff[`ST_FLOW];

  // ==========================================================
  // default values derived from the straps
  logic [`DEF_W-1:0] def_value;
  logic              energy_ok;

  always_comb begin
    def_value = '0;
    // no energy saving in fx mode
    energy_ok = st_energy && !s_fx;
    def_value[`DF_MAC_ENERGY] = energy_ok;
    def_value[`DF_PHY_ENERGY] = energy_ok;
    def_value[`DF_PHY_CAP]    = energy_ok;
    def_value[`DF_PHY_ADV]    = energy_ok;
    def_value[`DF_P100_FD]    = st_speed && st_duplex;
    def_value[`DF_P100_HD]    = st_speed && !st_duplex;
    def_value[`DF_P10_FD]     = !st_speed && st_duplex;
    def_value[`DF_P10_HD]     = !st_speed && !st_duplex;
    def_value[`DF_ASYM_PAUSE] = st_flow;
    def_value[`DF_PAUSE]      = st_flow;
    def_value[`DF_BACKPRESS]  = strap_ff[`ST_BACKPRESS];
    def_value[`DF_TX_FLOW]    = st_flow;
    def_value[`DF_RX_FLOW]    = st_flow;
  end

  // ==========================================================
  // target bits
  logic [`DEF_W-1:0] targets_ff;
  logic              applied_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      targets_ff <= `DEF_RESET;
    end else if (apply_now) begin
      targets_ff <= def_value;
    end else if (wr_defaults) begin
      targets_ff <= hwdata[`DEF_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_ff <= 1'b0;
    end else if (apply_now) begin
      applied_ff <= 1'b1;
    end
  end

  assign mac_energy_saving_enable     = targets_ff[`DF_MAC_ENERGY];
  assign phy_energy_saving_enable     = targets_ff[`DF_PHY_ENERGY];
  assign phy_energy_saving_capability = targets_ff[`DF_PHY_CAP];
  assign phy_energy_saving_advert     = targets_ff[`DF_PHY_ADV];
  assign virtual_phy_partner_ability  = targets_ff[`DF_P10_HD:`DF_P100_FD];
  assign virtual_phy_partner_pause    = targets_ff[`DF_PAUSE:`DF_ASYM_PAUSE];
  assign port0_backpressure_enable    = targets_ff[`DF_BACKPRESS];
  assign port0_tx_flow_enable         = targets_ff[`DF_TX_FLOW];
  assign port0_rx_flow_enable         = targets_ff[`DF_RX_FLOW];
  assign defaults_applied             = applied_ff;

  // ==========================================================
  // port 0 pin decode
  logic speed_100_ff;
  logic full_duplex_ff;
  logic link_100_ff;
  logic mode_rmii;
  logic mode_mii;

  assign mode_rmii = s_mode == `MODE_RMII_MAC;
  assign mode_mii  = s_mode == `MODE_MII_MAC;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_100_ff <= 1'b0;
    end else if (mode_rmii) begin
      // polarity 1 means high is 100
      speed_100_ff <= st_speed ? s_speed_pin : !s_speed_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_duplex_ff <= 1'b0;
    end else if (mode_rmii || mode_mii) begin
      // polarity 1 means high is full
      full_duplex_ff <= st_duplex ? s_duplex_pin : !s_duplex_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_100_ff <= 1'b0;
    end else begin
      link_100_ff <= s_an_fail ? st_speed : s_neg_100;
    end
  end

  assign port0_speed_100      = speed_100_ff;
  assign port0_full_duplex    = full_duplex_ff;
  assign port0_link_speed_100 = link_100_ff;

  // ==========================================================
  // read data
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req_addr)
      `REG_STRAP: begin
        rd_mux[`STRAP_W-1:0] = strap_ff;
      end
      `REG_DEFAULTS: begin
        rd_mux[`DEF_W-1:0] = targets_ff;
      end
      `REG_STATUS: begin
        rd_mux[`SS_SPEED_100]   = speed_100_ff;
        rd_mux[`SS_FULL_DUPLEX] = full_duplex_ff;
        rd_mux[`SS_LINK_100]    = link_100_ff;
        rd_mux[`SS_FX_MODE]     = s_fx;
        rd_mux[`SS_AN_FAIL]     = s_an_fail;
        rd_mux[`SS_BUSY]        = state_ff != soft_strap_pkg::st_run;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_req) begin
      rdata_ff <= rd_mux;
    end
  end

endmodule // soft_strap_default_apply
`default_nettype wire

// ==== testbench/eeprom_loader_model.sv ====
// eeprom loader model that hands strap words to the block
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
module eeprom_loader_model (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                req,
  input  wire logic [`STRAP_W-1:0] word,
  output logic                     eeprom_strap_valid,
  output logic [`STRAP_W-1:0]      eeprom_strap_data
);
  // ==========================================================
  // one-cycle strobe, data scrambles while idle
  // loader override word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eeprom_strap_valid <= 1'b0;
      eeprom_strap_data  <= '0;
    end else begin
      eeprom_strap_valid <= req;
      eeprom_strap_data  <= req ? word : ~eeprom_strap_data;
    end
  end
endmodule // eeprom_loader_model
`default_nettype wire

// ==== testbench/soft_strap_default_apply_asserts.sv ====
// concurrent checks on the soft-strap default block ports
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
module strap_checker (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic [1:0]          port0_mac_mode,
  input wire logic                phy_fx_mode,
  input wire logic                vphy_an_fail,
  input wire logic                vphy_an_speed_100,
  input wire logic                eeprom_strap_valid,
  input wire logic [`STRAP_W-1:0] eeprom_strap_data,
  input wire logic                mac_energy_saving_enable,
  input wire logic                phy_energy_saving_enable,
  input wire logic                phy_energy_saving_capability,
  input wire logic                phy_energy_saving_advert,
  input wire logic [3:0]          virtual_phy_partner_ability,
  input wire logic [1:0]          virtual_phy_partner_pause,
  input wire logic                port0_backpressure_enable,
  input wire logic                port0_tx_flow_enable,
  input wire logic                port0_rx_flow_enable,
  input wire logic                defaults_applied,
  input wire logic                port0_speed_100,
  input wire logic                port0_full_duplex,
  input wire logic                port0_link_speed_100
);
  // strap word seen two edges ago
  logic [`STRAP_W-1:0] d1, d2;
  always_ff @(posedge hclk) begin
    d1 <= eeprom_strap_data;
    d2 <= d1;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // loader sequences
  sequence s_load;
    eeprom_strap_valid ##2 1'b1;
  endsequence
  sequence s_load_tp;
    !phy_fx_mode [*4] ##0 s_load;
  endsequence
  sequence s_load_fx;
    phy_fx_mode [*4] ##0 s_load;
  endsequence
  // ==========================================================
  // properties
  property p_mac_energy;
    s_load_tp |-> mac_energy_saving_enable == d2[0];
  endproperty
  a_mac_energy: assert property (p_mac_energy) else $error("mac energy default wrong");
  property p_fx_off;
    s_load_fx |-> {mac_energy_saving_enable, phy_energy_saving_enable,
                   phy_energy_saving_capability, phy_energy_saving_advert} == 4'h0;
  endproperty
  a_fx_off: assert property (p_fx_off) else $error("energy default set in fx mode");
  property p_phy_energy;
    s_load |-> {phy_energy_saving_enable, phy_energy_saving_capability,
                phy_energy_saving_advert} == {3{mac_energy_saving_enable}};
  endproperty
  a_phy_energy: assert property (p_phy_energy) else $error("phy energy defaults disagree");
  property p_ability;
    s_load |-> virtual_phy_partner_ability ==
      {!d2[1] && !d2[2], !d2[1] && d2[2], d2[1] && !d2[2], d2[1] && d2[2]};
  endproperty
  a_ability: assert property (p_ability) else $error("partner ability default wrong");
  property p_flow;
    s_load |-> {virtual_phy_partner_pause, port0_tx_flow_enable, port0_rx_flow_enable,
                port0_backpressure_enable} == {{4{d2[4]}}, d2[3]};
  endproperty
  a_flow: assert property (p_flow) else $error("flow defaults wrong");
  property p_reset_dflt;
    $rose(defaults_applied) |-> {virtual_phy_partner_ability, virtual_phy_partner_pause,
      port0_backpressure_enable, port0_tx_flow_enable, port0_rx_flow_enable} == 9'h03f;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset defaults wrong");
  property p_link;
    (!vphy_an_fail && $stable(vphy_an_speed_100)) [*5] |-> port0_link_speed_100 == vphy_an_speed_100;
  endproperty
  a_link: assert property (p_link) else $error("link speed not negotiated one");
  property p_speed_hold;
    (port0_mac_mode != `MODE_RMII_MAC) [*5] |-> $stable(port0_speed_100);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed moved outside rmii mode");
  property p_duplex_hold;
    (port0_mac_mode != `MODE_RMII_MAC && port0_mac_mode != `MODE_MII_MAC) [*5] |-> $stable(port0_full_duplex);
  endproperty
  a_duplex_hold: assert property (p_duplex_hold) else $error("duplex moved outside mac modes");
endmodule // strap_checker
bind soft_strap_default_apply strap_checker i_strap_checker (
  .hclk, .hresetn, .port0_mac_mode, .phy_fx_mode, .vphy_an_fail, .vphy_an_speed_100,
  .eeprom_strap_valid, .eeprom_strap_data, .mac_energy_saving_enable, .phy_energy_saving_enable,
  .phy_energy_saving_capability, .phy_energy_saving_advert, .virtual_phy_partner_ability,
  .virtual_phy_partner_pause, .port0_backpressure_enable, .port0_tx_flow_enable, .port0_rx_flow_enable,
  .defaults_applied, .port0_speed_100, .port0_full_duplex, .port0_link_speed_100
);
`default_nettype wire

// ==== testbench/test_soft_strap_default_apply.sv ====
// self-checking bench for the soft-strap default block
`timescale 1ns/10ps
`default_nettype none
`include "soft_strap_defines.svh"
module test_soft_strap_default_apply;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp, ld_req, sp, fd;
  logic        energy_saving_strap_pin, port0_speed_pin, port0_duplex_pin, phy_fx_mode;
  logic        vphy_an_fail, vphy_an_speed_100, eeprom_strap_valid, defaults_applied;
  logic [1:0]  htrans, port0_mac_mode;
  logic [2:0]  hsize;
  logic [4:0]  ld_word, eeprom_strap_data;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [31:0] expq[$];
  int          n_errors = 0;
  int          n_tests = 0;
  assign hready = hreadyout;
  soft_strap_default_apply i_soft_strap_default_apply (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .energy_saving_strap_pin, .port0_speed_pin, .port0_duplex_pin, .port0_mac_mode,
    .phy_fx_mode, .vphy_an_fail, .vphy_an_speed_100, .eeprom_strap_valid, .eeprom_strap_data,
    .mac_energy_saving_enable(), .phy_energy_saving_enable(), .phy_energy_saving_capability(),
    .phy_energy_saving_advert(), .virtual_phy_partner_ability(), .virtual_phy_partner_pause(),
    .port0_backpressure_enable(), .port0_tx_flow_enable(), .port0_rx_flow_enable(),
    .defaults_applied, .port0_speed_100(), .port0_full_duplex(), .port0_link_speed_100()
  );
  eeprom_loader_model i_eeprom_loader_model (
    .hclk, .hresetn, .req(ld_req), .word(ld_word), .eeprom_strap_valid, .eeprom_strap_data
  );
  // ==========================================================
  // reporting
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // bus master
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      n_errors++;
      end_sim;
    end
  endtask
  // a read hands its expected word in d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= `HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) expq.push_back(d);
    rdy;
    rd_dp <= 1'b0;
  endtask
  always @(posedge hclk) begin
    if (rd_dp) begin
      if (expq.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk("hrdata", hrdata, expq.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
  end
  function automatic logic [31:0] dec(input logic [4:0] s, input logic f);
    logic e;
    e = s[0] & !f;
    return {19'h0, s[4], s[4], s[3], s[4], s[4], !s[1] & !s[2], !s[1] & s[2], s[1] & !s[2], s[1] & s[2], {4{e}}};
  endfunction
  task automatic do_reset(input logic pin);
    int i;
    energy_saving_strap_pin <= pin;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    i = 0;
    while (defaults_applied !== 1'b1 && i < 20) begin
      @(posedge hclk);
      i++;
    end
    if (i == 20) begin
      n_errors++;
      end_sim;
    end
    bus(1'b0, `REG_STRAP, {27'h0, 4'hf, pin});
    bus(1'b0, `REG_DEFAULTS, dec({4'hf, pin}, phy_fx_mode));
  endtask
  // ==========================================================
  // main sequence
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    end_sim;
  end
  initial begin
    {hsel, hsize} = {1'b1, 3'h2};
    {hresetn, hwrite, rd_dp, ld_req, sp, fd, htrans, ld_word, haddr, hwdata} = '0;
    {energy_saving_strap_pin, port0_speed_pin, port0_duplex_pin, port0_mac_mode} = '0;
    {phy_fx_mode, vphy_an_fail, vphy_an_speed_100} = '0;
    void'($urandom(32'h285e));
    do_reset(1'b1);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      {phy_fx_mode, vphy_an_speed_100, vphy_an_fail, port0_duplex_pin, port0_speed_pin, port0_mac_mode} <= r[11:5];
      repeat (5) @(posedge hclk);
      // strap changes only once the pins have settled, then one edge for the decode flops
      bus(1'b1, `REG_STRAP, r);
      @(posedge hclk);
      if (r[6:5] == `MODE_RMII_MAC) sp = r[1] ~^ r[7];
      if (r[6:5] == `MODE_RMII_MAC || r[6:5] == `MODE_MII_MAC) fd = r[2] ~^ r[8];
      bus(1'b0, `REG_STATUS, {26'h0, 1'b0, r[9], r[11], r[9] ? r[1] : r[10], fd, sp});
    end
    for (int i = 0; i < 32; i++) begin
      phy_fx_mode <= 1'($urandom);
      repeat (3) @(posedge hclk);
      ld_req <= 1'b1;
      ld_word <= 5'(i);
      @(posedge hclk);
      ld_req <= 1'b0;
      repeat (3) @(posedge hclk);
      bus(1'b0, `REG_STRAP, 32'(i));
      bus(1'b0, `REG_DEFAULTS, dec(5'(i), phy_fx_mode));
    end
    r = $urandom;
    bus(1'b1, `REG_STRAP, r);
    bus(1'b1, `REG_CTRL, 32'h1);
    repeat (3) @(posedge hclk);
    bus(1'b0, `REG_STRAP, {27'h0, r[4:0]});
    bus(1'b0, `REG_DEFAULTS, dec(r[4:0], phy_fx_mode));
    bus(1'b1, `REG_DEFAULTS, ~r);
    bus(1'b0, `REG_DEFAULTS, {19'h0, ~r[12:0]});
    bus(1'b0, 8'h10, 32'h0);
    bus(1'b0, `REG_CTRL, 32'h0);
    do_reset(r[0]);
    end_sim;
  end
endmodule // test_soft_strap_default_apply
`default_nettype wire
